// [rtl/pin_mux_pkg.sv]
// Package for the port pin function multiplexer: port widths, bit positions, reset values.
// Assumes one system clock and an asynchronous active-low chip reset.
package pin_mux_pkg;
  localparam int unsigned PORT_ZERO_W  = 4;
  localparam int unsigned PORT_ONE_W   = 8;
  localparam int unsigned PORT_TWO_W   = 3;
  localparam int unsigned PORT_THREE_W = 8;
  localparam int unsigned PORT_FOUR_W  = 8;
  localparam int unsigned PORT_SEVEN_W = 8;
  // Port one alternate bits
  localparam int unsigned P1_IRQ0_BIT  = 0;
  localparam int unsigned P1_IRQ1_BIT  = 1;
  localparam int unsigned P1_IRQ2_BIT  = 2;
  localparam int unsigned P1_DVO_BIT   = 3;
  localparam int unsigned P1_PPG_BIT   = 4;
  localparam int unsigned P1_TC2_BIT   = 5;
  // Port two alternate bits
  localparam int unsigned P2_STOP_BIT  = 0;
  localparam int unsigned P2_OSCI_BIT  = 1;
  localparam int unsigned P2_OSCO_BIT  = 2;
  // Port three alternate bits
  localparam int unsigned P3_TMR_LO    = 0;
  localparam int unsigned P3_SCK_BIT   = 3;
  localparam int unsigned P3_SI_BIT    = 4;
  localparam int unsigned P3_SO_BIT    = 5;
  // Port four alternate bits
  localparam int unsigned P4_RXA_BIT   = 1;
  localparam int unsigned P4_TXA_BIT   = 2;
  localparam int unsigned P4_RXB_BIT   = 4;
  localparam int unsigned P4_TXB_BIT   = 5;
  localparam int unsigned P4_TC3_BIT   = 6;
  // Port seven stop-release bits
  localparam int unsigned P7_STOP_LO   = 4;
  localparam int unsigned P7_STOP_N    = 4;
  // Reset values: latches all ones so inputs and alternate functions work, directions all zeros
  localparam logic [7:0]  LATCH_RESET  = 8'hff;
  localparam logic [7:0]  DIR_RESET    = 8'h00;
  // Reset pin stretch after an internal reset cause
  localparam int unsigned RST_OUT_NS   = 1000;
  localparam int unsigned CLK_NS       = 100;
  localparam int unsigned RST_OUT_CYC  = (RST_OUT_NS + CLK_NS - 1) / CLK_NS;
endpackage : pin_mux_pkg

// [rtl/pin_cell.sv]
// One bidirectional port cell: latch-gated alternate output, optional open-drain.
// Assumes latch, direction and alternate selects come from registers in the caller.
module pin_cell (
  input  wire logic latch_i,      // Output latch bit
  input  wire logic dir_out_i,    // Direction, 1 = output
  input  wire logic alt_en_i,     // Alternate output active
  input  wire logic alt_val_i,    // Peripheral output value
  input  wire logic open_drain_i, // Open-drain selected
  input  wire logic pad_i,        // Pin level
  output logic      pad_o,        // Pin drive value
  output logic      pad_oe_o,     // Pin drive enable
  output logic      in_o          // Value seen by core
);
  wire logic drive_val;
  assign drive_val = alt_en_i ? (alt_val_i & latch_i) : latch_i;
  assign pad_o     = open_drain_i ? 1'b0 : drive_val;
  assign pad_oe_o  = dir_out_i & (open_drain_i ? ~drive_val : 1'b1);
  assign in_o      = pad_i;
endmodule : pin_cell

// [rtl/port_pin_function_mux.sv]
// Port pin multiplexer: plain I/O ports plus alternate peripheral routing.
// Assumes software-written latch, direction and select bits arrive as plain ports, pins are synchronous.
module port_pin_function_mux
  import pin_mux_pkg::*;
// Overview of operation
// - Port zero: four bits, per-bit direction
// - Open-drain needs enable and direction set
// - Serial unit uses bits 1/2 or 4/5
// - Port one bits 0-2 carry interrupts, timer
// - Port two bits 1/2 slow oscillator
// - Port seven bits 4-7 extra stop release
// - Reset pin in and out, watchdog, trap
#(
  parameter int unsigned RST_HOLD = RST_OUT_CYC
) (
  input  wire logic                    clk_i,                       // System clock
  input  wire logic                    reset_n_i,                   // Chip reset, active low
  // Software latches and directions
  input  wire logic [PORT_ZERO_W-1:0]  port_zero_latch_i,           // Port zero output latch
  input  wire logic [PORT_ZERO_W-1:0]  port_zero_dir_i,             // Port zero direction
  input  wire logic [PORT_ONE_W-1:0]   port_one_latch_i,            // Port one output latch
  input  wire logic [PORT_ONE_W-1:0]   port_one_dir_i,              // Port one direction
  input  wire logic [PORT_TWO_W-1:0]   port_two_latch_i,            // Port two output latch
  input  wire logic [PORT_THREE_W-1:0] port_three_latch_i,          // Port three output latch
  input  wire logic [PORT_THREE_W-1:0] port_three_dir_i,            // Port three direction
  input  wire logic [PORT_FOUR_W-1:0]  port_four_latch_i,           // Port four output latch
  input  wire logic [PORT_FOUR_W-1:0]  port_four_direction_control_i, // Port four direction
  input  wire logic [PORT_FOUR_W-1:0]  port_four_open_drain_enable_i, // Port four open-drain
  input  wire logic [PORT_SEVEN_W-1:0] port_seven_latch_i,          // Port seven output latch
  input  wire logic [PORT_SEVEN_W-1:0] port_seven_dir_i,            // Port seven direction
  // Alternate function selects and peripheral outputs
  input  wire logic                    divider_out_en_i,            // Divider output select
  input  wire logic                    divider_out_i,               // Divider value
  input  wire logic                    pulse_pattern_out_en_i,      // Pulse generator select
  input  wire logic                    pulse_pattern_out_i,         // Pulse generator value
  input  wire logic [2:0]              modulated_out_en_i,          // Port three bits 0-2 output select
  input  wire logic [2:0]              modulated_out_i,             // Modulated / divided pulse values
  input  wire logic                    serial_out_en_i,             // Serial data out select
  input  wire logic                    serial_out_i,                // Serial data out value
  input  wire logic                    serial_clk_out_en_i,         // Serial clock out select
  input  wire logic                    serial_clk_out_i,            // Serial clock out value
  input  wire logic                    async_enable_i,              // Asynchronous unit on
  input  wire logic                    async_pin_select_i,          // 0 = bits 1/2, 1 = bits 4/5
  input  wire logic                    async_tx_i,                  // Asynchronous transmit value
  input  wire logic                    slow_osc_enable_i,           // Slow oscillator on
  input  wire logic                    slow_osc_drive_i,            // Slow oscillator amplifier out
  input  wire logic                    watchdog_reset_i,            // Watchdog reset request
  input  wire logic                    address_trap_reset_i,        // Address trap reset request
  // Pins
  input  wire logic [PORT_ZERO_W-1:0]  port_zero_pad_i,             // Port zero pin level
  output logic      [PORT_ZERO_W-1:0]  port_zero_pad_o,             // Port zero drive
  output logic      [PORT_ZERO_W-1:0]  port_zero_pad_oe_o,          // Port zero enable
  input  wire logic [PORT_ONE_W-1:0]   port_one_pad_i,              // Port one pin level
  output logic      [PORT_ONE_W-1:0]   port_one_pad_o,              // Port one drive
  output logic      [PORT_ONE_W-1:0]   port_one_pad_oe_o,           // Port one enable
  input  wire logic [PORT_TWO_W-1:0]   port_two_pad_i,              // Port two pin level
  output logic      [PORT_TWO_W-1:0]   port_two_pad_o,              // Port two drive
  output logic      [PORT_TWO_W-1:0]   port_two_pad_oe_o,           // Port two enable
  input  wire logic [PORT_THREE_W-1:0] port_three_pad_i,            // Port three pin level
  output logic      [PORT_THREE_W-1:0] port_three_pad_o,            // Port three drive
  output logic      [PORT_THREE_W-1:0] port_three_pad_oe_o,         // Port three enable
  input  wire logic [PORT_FOUR_W-1:0]  port_four_pad_i,             // Port four pin level
  output logic      [PORT_FOUR_W-1:0]  port_four_pad_o,             // Port four drive
  output logic      [PORT_FOUR_W-1:0]  port_four_pad_oe_o,          // Port four enable
  input  wire logic [PORT_SEVEN_W-1:0] port_seven_pad_i,            // Port seven pin level
  output logic      [PORT_SEVEN_W-1:0] port_seven_pad_o,            // Port seven drive
  output logic      [PORT_SEVEN_W-1:0] port_seven_pad_oe_o,         // Port seven enable
  input  wire logic                    reset_pad_i,                 // Reset pin level
  output logic                         reset_pad_o,                 // Reset pin drive, always 0
  output logic                         reset_pad_oe_o,              // Reset pin pulling low
  // Core-side inputs
  output logic [PORT_ZERO_W-1:0]       port_zero_in_o,              // Port zero read data
  output logic [PORT_ONE_W-1:0]        port_one_in_o,               // Port one read data
  output logic [PORT_TWO_W-1:0]        port_two_in_o,               // Port two read data
  output logic [PORT_THREE_W-1:0]      port_three_in_o,             // Port three read data
  output logic [PORT_FOUR_W-1:0]       port_four_in_o,              // Port four read data
  output logic [PORT_SEVEN_W-1:0]      port_seven_in_o,             // Port seven read data
  output logic                         ext_irq_zero_o,              // External interrupt 0
  output logic                         ext_irq_one_o,               // External interrupt 1
  output logic                         ext_irq_two_o,               // External interrupt 2
  output logic                         timer_input_one_o,           // Timer counter 1 input
  output logic                         timer_input_two_o,           // Timer counter 2 input
  output logic                         timer_input_three_o,         // Timer counter 3 input
  output logic [2:0]                   timer_inputs_high_o,         // Timer counters 4-6 inputs
  output logic                         serial_in_o,                 // Serial data in
  output logic                         serial_clk_in_o,             // Serial clock in
  output logic                         async_rx_o,                  // Asynchronous receive data
  output logic                         stop_release_main_o,         // Main stop release input
  output logic [P7_STOP_N-1:0]         stop_release_extra_o,        // Extra stop release inputs
  output logic                         slow_osc_in_o,               // Slow oscillator input
  output logic                         external_reset_o             // External reset seen on pin
);
  // Port one alternate selects
  wire logic [PORT_ONE_W-1:0]   p1_alt_en;
  wire logic [PORT_ONE_W-1:0]   p1_alt_val;
  assign p1_alt_en  = 8'(({7'h00, divider_out_en_i} << P1_DVO_BIT)
                     | ({7'h00, pulse_pattern_out_en_i} << P1_PPG_BIT));
  assign p1_alt_val = 8'(({7'h00, divider_out_i} << P1_DVO_BIT)
                     | ({7'h00, pulse_pattern_out_i} << P1_PPG_BIT));

  // Port three alternate selects
  wire logic [PORT_THREE_W-1:0] p3_alt_en;
  wire logic [PORT_THREE_W-1:0] p3_alt_val;
  assign p3_alt_en  = {2'b00, serial_out_en_i, 1'b0, serial_clk_out_en_i, modulated_out_en_i};
  assign p3_alt_val = {2'b00, serial_out_i, 1'b0, serial_clk_out_i, modulated_out_i};

  // Port four serial pair selection
  wire logic [PORT_FOUR_W-1:0]  p4_alt_en;
  wire logic [PORT_FOUR_W-1:0]  p4_alt_val;
  wire logic                    async_rx_first;
  wire logic                    async_rx_second;
  assign p4_alt_en  = async_enable_i ? 8'(8'h01 << (async_pin_select_i ? P4_TXB_BIT : P4_TXA_BIT))
                                     : 8'h00;
  assign p4_alt_val = {PORT_FOUR_W{async_tx_i}};
  assign async_rx_first  = port_four_pad_i[P4_RXA_BIT];
  assign async_rx_second = port_four_pad_i[P4_RXB_BIT];
  assign async_rx_o      = async_pin_select_i ? async_rx_second : async_rx_first;

  // Port two: stop input plus slow oscillator pins
  wire logic [PORT_TWO_W-1:0]   p2_dir;
  wire logic [PORT_TWO_W-1:0]   p2_alt_en;
  wire logic [PORT_TWO_W-1:0]   p2_alt_val;
  assign p2_dir     = {slow_osc_enable_i, 1'b0, 1'b0} | ~port_two_latch_i; // Latch zero pulls low
  assign p2_alt_en  = {slow_osc_enable_i, 2'b00};
  assign p2_alt_val = {slow_osc_drive_i, 2'b00};

  wire logic [PORT_FOUR_W-1:0]  p4_od;
  assign p4_od = port_four_open_drain_enable_i & port_four_direction_control_i;

  // Pin cells, one generate loop per port
  genvar g;
  generate
    for (g = 0; g < PORT_ZERO_W; g++) begin : g_p0
      pin_cell u_cell (.latch_i(port_zero_latch_i[g]), .dir_out_i(port_zero_dir_i[g]),
        .alt_en_i(1'b0), .alt_val_i(1'b0), .open_drain_i(1'b0), .pad_i(port_zero_pad_i[g]),
        .pad_o(port_zero_pad_o[g]), .pad_oe_o(port_zero_pad_oe_o[g]), .in_o(port_zero_in_o[g]));
    end
    for (g = 0; g < PORT_ONE_W; g++) begin : g_p1
      pin_cell u_cell (.latch_i(port_one_latch_i[g]), .dir_out_i(port_one_dir_i[g]),
        .alt_en_i(p1_alt_en[g]), .alt_val_i(p1_alt_val[g]), .open_drain_i(1'b0),
        .pad_i(port_one_pad_i[g]), .pad_o(port_one_pad_o[g]), .pad_oe_o(port_one_pad_oe_o[g]),
        .in_o(port_one_in_o[g]));
    end
    for (g = 0; g < PORT_TWO_W; g++) begin : g_p2
      pin_cell u_cell (.latch_i(port_two_latch_i[g]), .dir_out_i(p2_dir[g]),
        .alt_en_i(p2_alt_en[g]), .alt_val_i(p2_alt_val[g]), .open_drain_i(1'b0),
        .pad_i(port_two_pad_i[g]), .pad_o(port_two_pad_o[g]), .pad_oe_o(port_two_pad_oe_o[g]),
        .in_o(port_two_in_o[g]));
    end
    for (g = 0; g < PORT_THREE_W; g++) begin : g_p3
      pin_cell u_cell (.latch_i(port_three_latch_i[g]), .dir_out_i(port_three_dir_i[g]),
        .alt_en_i(p3_alt_en[g]), .alt_val_i(p3_alt_val[g]), .open_drain_i(1'b0),
        .pad_i(port_three_pad_i[g]), .pad_o(port_three_pad_o[g]), .pad_oe_o(port_three_pad_oe_o[g]),
        .in_o(port_three_in_o[g]));
    end
    for (g = 0; g < PORT_FOUR_W; g++) begin : g_p4
      pin_cell u_cell (.latch_i(port_four_latch_i[g]), .dir_out_i(port_four_direction_control_i[g]),
        .alt_en_i(p4_alt_en[g]), .alt_val_i(p4_alt_val[g]), .open_drain_i(p4_od[g]),
        .pad_i(port_four_pad_i[g]), .pad_o(port_four_pad_o[g]), .pad_oe_o(port_four_pad_oe_o[g]),
        .in_o(port_four_in_o[g]));
    end
    for (g = 0; g < PORT_SEVEN_W; g++) begin : g_p7
      pin_cell u_cell (.latch_i(port_seven_latch_i[g]), .dir_out_i(port_seven_dir_i[g]),
        .alt_en_i(1'b0), .alt_val_i(1'b0), .open_drain_i(1'b0), .pad_i(port_seven_pad_i[g]),
        .pad_o(port_seven_pad_o[g]), .pad_oe_o(port_seven_pad_oe_o[g]), .in_o(port_seven_in_o[g]));
    end
  endgenerate

  // Alternate inputs routed to peripherals
  assign ext_irq_zero_o       = port_one_pad_i[P1_IRQ0_BIT];
  assign ext_irq_one_o        = port_one_pad_i[P1_IRQ1_BIT];
  assign ext_irq_two_o        = port_one_pad_i[P1_IRQ2_BIT];
  assign timer_input_one_o    = port_one_pad_i[P1_IRQ2_BIT];
  assign timer_input_two_o    = port_one_pad_i[P1_TC2_BIT];
  assign timer_input_three_o  = port_four_pad_i[P4_TC3_BIT];
  assign timer_inputs_high_o  = port_three_pad_i[P3_TMR_LO +: 3];
  assign serial_in_o          = port_three_pad_i[P3_SI_BIT];
  assign serial_clk_in_o      = port_three_pad_i[P3_SCK_BIT];
  assign stop_release_main_o  = port_two_pad_i[P2_STOP_BIT];
  assign stop_release_extra_o = port_seven_pad_i[P7_STOP_LO +: P7_STOP_N];
  assign slow_osc_in_o        = slow_osc_enable_i & port_two_pad_i[P2_OSCI_BIT];

  // Reset pin: stretch internal reset causes onto the open-drain pin
  logic [$clog2(RST_HOLD+1)-1:0] rst_cnt;
  wire logic                     int_reset_req;
  assign int_reset_req = watchdog_reset_i | address_trap_reset_i;

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rst_cnt <= '0;
    end else if (int_reset_req) begin
      rst_cnt <= ($clog2(RST_HOLD+1))'(RST_HOLD);
    end else if (rst_cnt != '0) begin
      rst_cnt <= rst_cnt - 1'b1;
    end
  end

  assign reset_pad_o      = 1'b0;
  assign reset_pad_oe_o   = (rst_cnt != '0);
  assign external_reset_o = ~reset_pad_i & ~reset_pad_oe_o;
endmodule : port_pin_function_mux

// [tb/port_mux_checker.sv]
// Checker for the port pin multiplexer: pin drive, input routing and reset pin stretch.
// Assumes it is bound into port_pin_function_mux and sees only that module's ports.
module port_mux_checker
  import pin_mux_pkg::*;
#(
  parameter int unsigned RST_HOLD = 2
) (
  input wire logic       clk_i, reset_n_i, divider_out_en_i, divider_out_i, pulse_pattern_out_en_i,   // Controls
  input wire logic       pulse_pattern_out_i, async_enable_i, async_pin_select_i, async_tx_i,        // Selects
  input wire logic       slow_osc_enable_i, slow_osc_in_o, watchdog_reset_i, address_trap_reset_i,   // Sources
  input wire logic       ext_irq_zero_o, ext_irq_one_o, ext_irq_two_o, timer_input_one_o, async_rx_o, // Routed
  input wire logic       reset_pad_i, reset_pad_o, reset_pad_oe_o, external_reset_o,                 // Reset pin
  input wire logic [3:0] port_zero_latch_i, port_zero_dir_i, port_zero_pad_o, port_zero_pad_oe_o,    // Port zero
  input wire logic [3:0] stop_release_extra_o,                                                       // Stop inputs
  input wire logic [2:0] port_two_pad_i,                                                             // Port two pin
  input wire logic [7:0] port_one_latch_i, port_one_dir_i, port_one_pad_i, port_one_pad_o,           // Port one
  input wire logic [7:0] port_four_latch_i, port_four_direction_control_i, port_four_pad_i,          // Port four
  input wire logic [7:0] port_four_open_drain_enable_i, port_four_pad_o, port_four_pad_oe_o,         // Port four
  input wire logic [7:0] port_seven_pad_i                                                            // Port seven
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);
  logic [7:0] hold_cnt;
  wire        req = watchdog_reset_i | address_trap_reset_i;
  wire [7:0]  od_bits = port_four_open_drain_enable_i & port_four_direction_control_i;
  // Reference stretch count, loaded at each request
  always_ff @(posedge clk_i or negedge reset_n_i)
    if (!reset_n_i) hold_cnt <= 8'h00;
    else if (req) hold_cnt <= 8'(RST_HOLD);
    else if (hold_cnt != 8'h00) hold_cnt <= hold_cnt - 8'h01;
  AST_P0_DIR: assert property (port_zero_pad_oe_o == port_zero_dir_i &&
    ((port_zero_pad_o ^ port_zero_latch_i) & port_zero_dir_i) == 4'h0) else $error("port zero drive wrong");
  AST_DVO: assert property (divider_out_en_i && port_one_dir_i[3] |->
    port_one_pad_o[3] == (divider_out_i & port_one_latch_i[3])) else $error("divider pin wrong");
  AST_PPG: assert property (pulse_pattern_out_en_i && port_one_dir_i[4] |->
    port_one_pad_o[4] == (pulse_pattern_out_i & port_one_latch_i[4])) else $error("pulse pin wrong");
  AST_IRQ: assert property ({ext_irq_two_o, ext_irq_one_o, ext_irq_zero_o, timer_input_one_o} ==
    {port_one_pad_i[2:0], port_one_pad_i[2]}) else $error("interrupt routing wrong");
  AST_OSC: assert property (slow_osc_in_o == (slow_osc_enable_i & port_two_pad_i[1]))
    else $error("slow clock input wrong");
  AST_STOP: assert property (stop_release_extra_o == port_seven_pad_i[7:4])
    else $error("stop release routing wrong");
  AST_OD: assert property (!async_enable_i |-> (port_four_pad_o & port_four_pad_oe_o & od_bits) == 8'h00 &&
    port_four_pad_oe_o == (port_four_direction_control_i & ~(od_bits & port_four_latch_i)))
    else $error("port four drive wrong");
  AST_UART_RX: assert property (async_enable_i |->
    async_rx_o == (async_pin_select_i ? port_four_pad_i[4] : port_four_pad_i[1])) else $error("receive pin wrong");
  AST_UART_TX: assert property (async_enable_i && !async_pin_select_i && port_four_direction_control_i[2] &&
    !port_four_open_drain_enable_i[2] |-> port_four_pad_o[2] == (async_tx_i & port_four_latch_i[2]))
    else $error("transmit pin wrong");
  AST_RST_REQ: assert property (req |=> reset_pad_oe_o [*2])
    else $error("reset pin not driven after request");
  AST_RST_HOLD: assert property (reset_pad_oe_o == (hold_cnt != 8'h00))
    else $error("reset pin stretch wrong");
  AST_RST_PIN: assert property (external_reset_o == (!reset_pad_i && !reset_pad_oe_o) &&
    !(reset_pad_oe_o && reset_pad_o)) else $error("reset pin sense wrong");
  cover property (req);
  cover property ($fell(reset_pad_oe_o));
  cover property (async_enable_i && async_pin_select_i);
endmodule : port_mux_checker

bind port_pin_function_mux port_mux_checker #(.RST_HOLD(RST_HOLD)) chk (.*);

// [tb/board_pins.sv]
// Board model of one port: resolves each pin from chip drive, board drive and pull-ups.
// Assumes a pull-up on every pin, so a released line reads high; a low driver wins.
module board_pins #(
  parameter int unsigned W = 8
) (
  input  wire logic [W-1:0] pad_i,      // Chip drive value
  input  wire logic [W-1:0] oe_i,       // Chip drive enable
  input  wire logic [W-1:0] drive_i,    // Board drive value
  input  wire logic [W-1:0] drive_en_i, // Board drive enable
  output logic      [W-1:0] pin_o       // Resolved pin level
);
  timeunit 1ns;
  timeprecision 100ps;
  assign pin_o = ~((oe_i & ~pad_i) | (drive_en_i & ~drive_i));
endmodule : board_pins

// [tb/test_port_pin_function_mux.sv]
// Testbench for the port pin multiplexer: table of port four cases, then hand-written cases.
// Assumes board pull-ups on all pins and a short reset stretch.
module test_port_pin_function_mux;
  import pin_mux_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int unsigned HOLD = 3;
  typedef struct packed {logic [7:0] latch, dir, ode, oe;} row_t;
  logic clk_i, reset_n_i, divider_out_en_i, divider_out_i, pulse_pattern_out_en_i, pulse_pattern_out_i, rd, re;
  logic serial_out_en_i, serial_out_i, serial_clk_out_en_i, serial_clk_out_i, async_enable_i, async_pin_select_i;
  logic async_tx_i, slow_osc_enable_i, slow_osc_drive_i, watchdog_reset_i, address_trap_reset_i, reset_pad_i;
  logic reset_pad_o, reset_pad_oe_o, ext_irq_zero_o, ext_irq_one_o, ext_irq_two_o, timer_input_one_o, serial_in_o;
  logic timer_input_two_o, timer_input_three_o, serial_clk_in_o, async_rx_o, stop_release_main_o, slow_osc_in_o;
  logic external_reset_o;
  logic [3:0] port_zero_latch_i, port_zero_dir_i, port_zero_pad_i, port_zero_pad_o, port_zero_pad_oe_o;
  logic [3:0] port_zero_in_o, stop_release_extra_o;
  logic [2:0] port_two_latch_i, port_two_pad_i, port_two_pad_o, port_two_pad_oe_o, port_two_in_o;
  logic [2:0] modulated_out_en_i, modulated_out_i, timer_inputs_high_o;
  logic [7:0] port_one_latch_i, port_one_dir_i, port_one_pad_i, port_one_pad_o, port_one_pad_oe_o, port_one_in_o;
  logic [7:0] port_three_latch_i, port_three_dir_i, port_three_pad_i, port_three_pad_o, port_three_pad_oe_o;
  logic [7:0] port_four_latch_i, port_four_direction_control_i, port_four_open_drain_enable_i, port_four_pad_i;
  logic [7:0] port_four_pad_o, port_four_pad_oe_o, port_four_in_o, port_three_in_o, bd, be;
  logic [7:0] port_seven_latch_i, port_seven_dir_i, port_seven_pad_i, port_seven_pad_o, port_seven_pad_oe_o;
  logic [7:0] port_seven_in_o;
  int   mismatches, checked, n;
  row_t rows [4] = '{'{8'hff, 8'hff, 8'h00, 8'hff}, '{8'h0f, 8'hff, 8'hff, 8'hf0},
                     '{8'ha5, 8'h3c, 8'h0f, 8'h38}, '{8'h00, 8'h00, 8'hff, 8'h00}};
  port_pin_function_mux #(.RST_HOLD(HOLD)) uut (.*);
  board_pins #(.W(4)) b0 (.pad_i(port_zero_pad_o), .oe_i(port_zero_pad_oe_o), .drive_i(bd[3:0]),
    .drive_en_i(be[3:0]), .pin_o(port_zero_pad_i));
  board_pins #(.W(8)) b1 (.pad_i(port_one_pad_o), .oe_i(port_one_pad_oe_o), .drive_i(bd), .drive_en_i(be),
    .pin_o(port_one_pad_i));
  board_pins #(.W(3)) b2 (.pad_i(port_two_pad_o), .oe_i(port_two_pad_oe_o), .drive_i(bd[2:0]),
    .drive_en_i(be[2:0]), .pin_o(port_two_pad_i));
  board_pins #(.W(8)) b3 (.pad_i(port_three_pad_o), .oe_i(port_three_pad_oe_o), .drive_i(bd), .drive_en_i(be),
    .pin_o(port_three_pad_i));
  board_pins #(.W(8)) b4 (.pad_i(port_four_pad_o), .oe_i(port_four_pad_oe_o), .drive_i(bd), .drive_en_i(be),
    .pin_o(port_four_pad_i));
  board_pins #(.W(8)) b7 (.pad_i(port_seven_pad_o), .oe_i(port_seven_pad_oe_o), .drive_i(bd), .drive_en_i(be),
    .pin_o(port_seven_pad_i));
  board_pins #(.W(1)) br (.pad_i(reset_pad_o), .oe_i(reset_pad_oe_o), .drive_i(rd), .drive_en_i(re),
    .pin_o(reset_pad_i));
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic finish_test;
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : finish_test
  task automatic step;
    @(negedge clk_i);
  endtask : step
  initial begin
    clk_i = 1'b0;
    forever #50 clk_i = ~clk_i;
  end
  initial begin
    reset_n_i = 1'b0;
    {port_zero_dir_i, port_one_dir_i, port_three_dir_i, port_seven_dir_i, port_four_direction_control_i} = '0;
    {port_four_open_drain_enable_i, modulated_out_en_i, modulated_out_i, divider_out_en_i, divider_out_i} = '0;
    {pulse_pattern_out_en_i, pulse_pattern_out_i, serial_out_en_i, serial_out_i, serial_clk_out_en_i} = '0;
    {serial_clk_out_i, async_enable_i, async_pin_select_i, async_tx_i, slow_osc_enable_i, slow_osc_drive_i} = '0;
    {watchdog_reset_i, address_trap_reset_i, bd, be, rd, re} = '0;
    {port_zero_latch_i, port_one_latch_i, port_three_latch_i, port_four_latch_i, port_seven_latch_i} = '1;
    port_two_latch_i = 3'h7;
    repeat (8) step();
    reset_n_i = 1'b1;
    #10 check(reset_pad_oe_o, 1'b0);
    foreach (rows[i]) begin
      step();
      {port_four_latch_i, port_four_direction_control_i, port_four_open_drain_enable_i} = rows[i][31:8];
      #10 check(port_four_pad_oe_o, rows[i].oe);
      check(port_four_in_o, ~(rows[i].oe & ~rows[i].latch));
    end
    step();
    {port_four_latch_i, port_four_open_drain_enable_i, port_zero_dir_i, port_zero_latch_i} = {8'hff, 8'h00, 8'h62};
    {port_one_dir_i, divider_out_en_i, divider_out_i, pulse_pattern_out_en_i} = {8'h18, 3'h7};
    #10 check(port_zero_pad_oe_o, 4'h6);
    check(port_zero_in_o, 4'hb);
    check(port_one_pad_o & 8'h18, 8'h08);
    step();
    {port_one_latch_i, port_one_dir_i, bd, be} = {8'hf7, 8'h08, 8'h05, 8'h07};
    #10 check(port_one_pad_o[3], 1'b0);
    check({ext_irq_two_o, ext_irq_one_o, ext_irq_zero_o, timer_input_one_o}, 4'hb);
    step();
    {slow_osc_enable_i, bd, be} = {1'b1, 8'h50, 8'hf2};
    #10 check(slow_osc_in_o, 1'b0);
    check(stop_release_extra_o, 4'h5);
    step();
    {port_three_dir_i, port_three_latch_i, modulated_out_en_i, modulated_out_i} = {8'h2f, 8'hfd, 6'h3d};
    {serial_out_en_i, serial_out_i, serial_clk_out_en_i, serial_clk_out_i, port_two_latch_i, slow_osc_drive_i} = 8'hbd;
    {port_seven_dir_i, port_seven_latch_i, bd, be} = {8'h0f, 8'h5a, 8'h00, 8'h70};
    #10 check(port_three_pad_o, 8'hdd);
    check(port_three_pad_oe_o, 8'h2f);
    check(port_three_in_o, 8'h8d);
    check({serial_in_o, serial_clk_in_o, timer_inputs_high_o}, 8'h0d);
    check({port_two_pad_oe_o, port_two_in_o, stop_release_main_o, slow_osc_in_o}, 8'hb9);
    check(port_seven_in_o, 8'h8a);
    check(port_one_in_o, 8'h87);
    check({timer_input_two_o, timer_input_three_o, port_seven_pad_oe_o[3:0]}, 8'h0f);
    for (int s = 0; s < 2; s++) begin
      step();
      {async_enable_i, async_pin_select_i, async_tx_i, port_four_direction_control_i} = {2'(s + 2), 1'b0, 8'h24};
      {bd, be} = {8'h00, (s == 1) ? 8'h10 : 8'h02};
      #10 check(async_rx_o, 1'b0);
      check(port_four_pad_o[s * 3 + 2], 1'b0);
      step();
      async_tx_i = 1'b1;
      #10 check(port_four_pad_o[s * 3 + 2], 1'b1);
    end
    for (int s = 0; s < 2; s++) begin
      step();
      {watchdog_reset_i, address_trap_reset_i} = 2'(2'b10 >> s);
      step();
      {watchdog_reset_i, address_trap_reset_i, n} = '0;
      check(external_reset_o, 1'b0);
      while (reset_pad_oe_o === 1'b1 && n < 50) begin
        n++;
        step();
      end
      check(8'(n), 8'(HOLD));
      if (n == 50) finish_test();
    end
    step();
    watchdog_reset_i = 1'b1;
    step();
    {watchdog_reset_i, reset_n_i, rd, re} = 4'h1;
    #10 check(reset_pad_oe_o, 1'b0);
    check(external_reset_o, 1'b1);
    step();
    reset_n_i = 1'b1;
    finish_test();
  end
endmodule : test_port_pin_function_mux
